/* File: mpfc_top.sv */
// Pause and priority flow control core with an APB register slave.
// Assumes a MAC front end that delivers parsed headers and takes
// generated pause frames with valid/ready, all on one clock.
// Operation
// RL1: Nine receive enables gate only user outputs, never internal pause timing.
// RL2: Nine transmit enables; a class sends pause only when its bit is set.
// RL3: Global control frames qualify by enabled address, ethertype, opcode-range checks.
// RL4: Priority control frames use their own ethertype and opcode range checks.
// RL5: Global pause frames qualify by enabled checks with one exact opcode.
// RL6: Priority pause frames qualify by their own ethertype and exact opcode.
// RL7: A valid pause sets its request bit, held until processing ends.
// RL8: Acknowledge bits end requests only when waiting for acknowledge is on.
// RL9: Control frames are forwarded when forwarding is on, else dropped.
// RL10: Pause-valid bit per accepted pause; bit 8 marks global pause.
// RL11: Nine received quanta; priorities at 0..7, global at 8.
// RL12: A transmit request bit sends a pause frame; bit 8 means global.
// RL13: Software supplies nine transmit quanta, priorities 0..7 and global 8.
// RL14: Pause frames repeat at each class's refresh interval.
// RL15: Global pause frames carry their own addresses, ethertype and opcode.
// RL16: Priority pause frames carry separate addresses, ethertype and opcode.
// RL17: Resend restarts refresh counters and resends after the current frame.
// RL18: Resend should be pulsed for one cycle per request.
// RL19: Transmit pause-valid bits pulse when the matching frame was sent.
// RL20: Standard global pause frames with good check sequence pulse statistics.
// RL21: Priority pause frames with good check sequence pulse statistics.
// RL22: Receive and transmit controls and outputs share their own clock.
// RL23: Quanta and refresh values count 512 bit times at line rate; the tick rounds down to whole clocks, 2 cycles (500 bit times) here.
`timescale 1ns/1ps
`include "mpfc_map.svh"
module mpfc_top #(
	parameter int LINE_MBPS = `MPFC_LINE_MBPS
) (
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Parsed receive header, one strobe per frame
	input wire logic rxHdrValid,
	input wire logic rxHdrFcsGood,
	input wire mpfc_pkg::mpfc_mac_t rxHdrDa,
	input wire mpfc_pkg::mpfc_mac_t rxHdrSa,
	input wire mpfc_pkg::mpfc_word_t rxHdrEtype,
	input wire mpfc_pkg::mpfc_word_t rxHdrOpcode,
	input wire mpfc_pkg::mpfc_word_t rxHdrParam,
	input wire mpfc_pkg::mpfc_q8_t rxHdrTimes,
	// Receive user side
	input wire logic [8:0] rxPauseAck,
	output logic [8:0] rxPauseReq,
	output logic [8:0] rxPauseValid,
	output mpfc_pkg::mpfc_q9_t rxPauseQuanta,
	output logic [8:0] rxPaused,
	output logic rxCtrlForward,
	output logic rxCtrlDrop,
	output logic rxStatPause,
	output logic rxStatUserPause,
	// Transmit user side
	input wire logic [8:0] txPauseReq,
	input wire logic txResendPause,
	output logic [8:0] txPauseValid,
	output logic txStatPause,
	output logic txStatUserPause,
	// Generated frame towards the MAC transmitter
	output logic txFrmValid,
	input wire logic txFrmReady,
	output mpfc_pkg::mpfc_mac_t txFrmDa,
	output mpfc_pkg::mpfc_mac_t txFrmSa,
	output mpfc_pkg::mpfc_word_t txFrmEtype,
	output mpfc_pkg::mpfc_word_t txFrmOpcode,
	output mpfc_pkg::mpfc_word_t txFrmParam,
	output mpfc_pkg::mpfc_q8_t txFrmTimes,
	input wire logic txFrmDone,
	input wire logic txFrmDoneGood
);
	import mpfc_pkg::*;

	//----------------------------------------------------------------
	// Quantum tick
	//----------------------------------------------------------------
	localparam int QUANTUM_PS = `MPFC_QUANTUM_BITS * 1000000 / LINE_MBPS;
	localparam int TICK_RAW = QUANTUM_PS / `MPFC_CLK_PERIOD_PS;
	localparam int TICK_CYCLES = (TICK_RAW < 1) ? 1 : TICK_RAW;
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	logic [15:0] tickCnt;
	logic tick;

	// Rounded down so pauses never outlast the partner's view
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tickCnt <= 16'h0000;
			tick <= 1'b0;
		end else if (tickCnt == TICK_LAST) begin
			tickCnt <= 16'h0000;
			tick <= 1'b1; // RL23
		end else begin
			tickCnt <= tickCnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	//----------------------------------------------------------------
	// Register file and APB slave
	//----------------------------------------------------------------
	logic [31:0] cfg [`MPFC_NUM_CFG];
	logic [5:0] idx;
	logic aligned;
	logic [31:0] strbMask;
	logic [31:0] wsel;
	logic [31:0] rdWord;
	logic [31:0] status;
	mpfc_txst_t state;

	function automatic logic mapped(input logic [5:0] i);
		return i <= `MPFC_W_STATUS;
	endfunction

	// Bits outside a register's fields stay zero
	function automatic logic [31:0] wmask(input logic [5:0] i);
		case (i)
			`MPFC_W_RXCTL: return `MPFC_MASK_RXCTL;
			`MPFC_W_RXEN, `MPFC_W_TXEN: return `MPFC_MASK_NINE;
			`MPFC_W_UC_HI, `MPFC_W_MC_HI, `MPFC_W_SA_HI,
			`MPFC_W_TG_DA_HI, `MPFC_W_TG_SA_HI,
			`MPFC_W_TP_DA_HI, `MPFC_W_TP_SA_HI: return `MPFC_MASK_HI;
			default: return 32'hffffffff;
		endcase
	endfunction

	assign idx = paddr[7:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wsel = wmask(idx) & strbMask;
	assign status = {(state != TX_IDLE), 6'h00, rxPaused, 7'h00, rxPauseReq};

	// Read mux; status is live, never stored
	always_comb begin
		rdWord = 32'h00000000;
		if (idx == `MPFC_W_STATUS)
			rdWord = status;
		else if (idx < `MPFC_W_STATUS)
			rdWord = cfg[idx];
	end

	// Writes land at the access edge; status writes are ignored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < `MPFC_NUM_CFG; k++)
				cfg[k] <= `MPFC_RST_VAL;
		end else if (psel & penable & pready & pwrite & aligned
			& (idx < `MPFC_W_STATUS)) begin
			cfg[idx] <= (cfg[idx] & ~wsel) | (pwdata & wsel);
		end
	end

	// One wait-free answer: data and error latched in setup
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & !penable;
			if (psel & !penable) begin
				prdata <= (!pwrite & aligned & mapped(idx)) ? rdWord : 32'h00000000;
				pslverr <= !(aligned & mapped(idx));
			end
		end
	end

	//----------------------------------------------------------------
	// Configuration fields
	//----------------------------------------------------------------
	logic [31:0] rxCtl;
	logic [8:0] rxEn;
	logic [8:0] txEn;
	logic checkAck;
	logic fwdCtrl;
	mpfc_q9_t txQuanta;
	mpfc_core_if core ();

	assign rxCtl = cfg[`MPFC_W_RXCTL];
	assign rxEn = cfg[`MPFC_W_RXEN][8:0];
	assign txEn = cfg[`MPFC_W_TXEN][8:0];
	assign checkAck = rxCtl[`MPFC_RXCTL_ACK];
	assign fwdCtrl = rxCtl[`MPFC_RXCTL_FWD];

	// Matcher inputs; class order follows the class enumeration
	assign core.da = rxHdrDa;
	assign core.sa = rxHdrSa;
	assign core.etype = rxHdrEtype;
	assign core.opcode = rxHdrOpcode;
	assign core.ctrl = rxCtl;
	assign core.ucast = {cfg[`MPFC_W_UC_HI][15:0], cfg[`MPFC_W_UC_LO]};
	assign core.mcast = {cfg[`MPFC_W_MC_HI][15:0], cfg[`MPFC_W_MC_LO]};
	assign core.saCfg = {cfg[`MPFC_W_SA_HI][15:0], cfg[`MPFC_W_SA_LO]};
	assign core.etCfg = {cfg[`MPFC_W_RXET_P], cfg[`MPFC_W_RXET_C]}; // RL3 RL4 RL5 RL6
	assign core.opMin = {cfg[`MPFC_W_OPC_X], cfg[`MPFC_W_OPC_P][15:0],
		cfg[`MPFC_W_OPC_G][15:0]}; // RL3 RL4 RL5 RL6
	assign core.opMax = {cfg[`MPFC_W_OPC_X], cfg[`MPFC_W_OPC_P][31:16],
		cfg[`MPFC_W_OPC_G][31:16]}; // RL3 RL4 RL5 RL6

	// Timer inputs
	assign core.tick = tick;
	assign core.resend = txResendPause; // RL17
	assign core.req = txPauseReq;
	assign core.en = txEn; // RL2

	// Per-class quanta and refresh words
	always_comb begin
		for (int k = 0; k < 9; k++) begin
			core.refresh[k] = cfg[`MPFC_W_TIMES + k][31:16]; // RL14
			txQuanta[k] = cfg[`MPFC_W_TIMES + k][15:0]; // RL13
		end
	end

	mpfc_rx_match uMatch (
		.bus(core.matcher)
	);

	mpfc_tx_timer uTimer (
		.clk(clk),
		.rst_n(rst_n),
		.bus(core.timer)
	);

	//----------------------------------------------------------------
	// Receive pause processing
	//----------------------------------------------------------------
	logic ctrlFrame;
	logic pauseG;
	logic pauseP;
	logic [8:0] hit;
	mpfc_q9_t qIn;
	mpfc_q9_t rxTimer;

	// Bad check sequence never starts a pause
	assign ctrlFrame = rxHdrValid & (|core.match);
	assign pauseG = rxHdrValid & rxHdrFcsGood & core.match[CLS_GPP]; // RL5
	assign pauseP = rxHdrValid & rxHdrFcsGood & core.match[CLS_PPP]; // RL6
	assign hit = {pauseG, {8{pauseP}} & rxHdrParam[7:0]};
	assign qIn = {rxHdrParam, rxHdrTimes}; // RL11

	// Internal pause timers run whatever the receive enables say
	always_ff @(posedge clk) begin
		for (int k = 0; k < 9; k++) begin
			if (!rst_n)
				rxTimer[k] <= 16'h0000;
			else if (hit[k])
				rxTimer[k] <= qIn[k]; // RL23
			else if (tick & (rxTimer[k] != 16'h0000))
				rxTimer[k] <= rxTimer[k] - 16'h0001; // RL1
		end
	end

	// Requests: a new frame wins over an acknowledge in the same cycle
	always_ff @(posedge clk) begin
		for (int k = 0; k < 9; k++) begin
			if (!rst_n)
				rxPauseReq[k] <= 1'b0;
			else if (hit[k] & rxEn[k])
				rxPauseReq[k] <= 1'b1; // RL7 RL1
			else if (checkAck ? rxPauseAck[k] : (rxTimer[k] == 16'h0000))
				rxPauseReq[k] <= 1'b0; // RL8
		end
	end

	// Valid pulses and quanta held until the next accepted pause
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxPauseValid <= 9'h000;
			rxPauseQuanta <= '0;
		end else begin
			rxPauseValid <= hit & rxEn; // RL10 RL1
			for (int k = 0; k < 9; k++) begin
				if (hit[k] & rxEn[k])
					rxPauseQuanta[k] <= qIn[k]; // RL11
			end
		end
	end

	// Paused view, control-frame fate and receive statistics
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxPaused <= 9'h000;
			rxCtrlForward <= 1'b0;
			rxCtrlDrop <= 1'b0;
			rxStatPause <= 1'b0;
			rxStatUserPause <= 1'b0;
		end else begin
			for (int k = 0; k < 9; k++)
				rxPaused[k] <= (rxTimer[k] != 16'h0000);
			rxCtrlForward <= ctrlFrame & fwdCtrl; // RL9
			rxCtrlDrop <= ctrlFrame & !fwdCtrl; // RL9
			rxStatPause <= pauseG; // RL20
			rxStatUserPause <= pauseP; // RL21
		end
	end

	//----------------------------------------------------------------
	// Transmit pause generation
	//----------------------------------------------------------------
	logic [8:0] pend;
	logic [8:0] inflight;
	mpfc_q8_t pTimes;

	assign pend = core.pending & txEn; // RL2

	// Priority frame carries only the classes that are due
	always_comb begin
		for (int k = 0; k < 8; k++)
			pTimes[k] = pend[k] ? txQuanta[k] : 16'h0000;
	end

	// Global pause first; one frame in flight at a time.
	// The MAC raises ready only after its current frame ends.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= TX_IDLE;
			txFrmValid <= 1'b0;
			core.launch <= 9'h000;
			inflight <= 9'h000;
			txFrmDa <= '0;
			txFrmSa <= '0;
			txFrmEtype <= 16'h0000;
			txFrmOpcode <= 16'h0000;
			txFrmParam <= 16'h0000;
			txFrmTimes <= '0;
		end else begin
			core.launch <= 9'h000;
			unique case (state)
				TX_IDLE: begin
					if (pend[8]) begin
						txFrmDa <= {cfg[`MPFC_W_TG_DA_HI][15:0], cfg[`MPFC_W_TG_DA_LO]}; // RL15
						txFrmSa <= {cfg[`MPFC_W_TG_SA_HI][15:0], cfg[`MPFC_W_TG_SA_LO]}; // RL15
						txFrmEtype <= cfg[`MPFC_W_TX_ET][15:0]; // RL15
						txFrmOpcode <= cfg[`MPFC_W_TX_OP][15:0]; // RL15
						txFrmParam <= txQuanta[8]; // RL12
						txFrmTimes <= '0;
						inflight <= 9'h100;
						core.launch <= 9'h100; // RL12
						txFrmValid <= 1'b1;
						state <= TX_OFFER;
					end else if (|pend[7:0]) begin
						txFrmDa <= {cfg[`MPFC_W_TP_DA_HI][15:0], cfg[`MPFC_W_TP_DA_LO]}; // RL16
						txFrmSa <= {cfg[`MPFC_W_TP_SA_HI][15:0], cfg[`MPFC_W_TP_SA_LO]}; // RL16
						txFrmEtype <= cfg[`MPFC_W_TX_ET][31:16]; // RL16
						txFrmOpcode <= cfg[`MPFC_W_TX_OP][31:16]; // RL16
						txFrmParam <= {8'h00, pend[7:0]}; // RL12
						txFrmTimes <= pTimes;
						inflight <= {1'b0, pend[7:0]};
						core.launch <= {1'b0, pend[7:0]}; // RL12
						txFrmValid <= 1'b1;
						state <= TX_OFFER;
					end
				end
				TX_OFFER: begin
					if (txFrmReady) begin
						txFrmValid <= 1'b0; // RL17
						state <= TX_FLIGHT;
					end
				end
				TX_FLIGHT: begin
					if (txFrmDone)
						state <= TX_IDLE;
				end
				default: state <= TX_IDLE;
			endcase
		end
	end

	// Sent report and transmit statistics
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txPauseValid <= 9'h000;
			txStatPause <= 1'b0;
			txStatUserPause <= 1'b0;
		end else begin
			txPauseValid <= (state == TX_FLIGHT && txFrmDone) ? inflight : 9'h000; // RL19
			txStatPause <= (state == TX_FLIGHT) & txFrmDone & txFrmDoneGood
				& inflight[8]; // RL20
			txStatUserPause <= (state == TX_FLIGHT) & txFrmDone & txFrmDoneGood
				& !inflight[8]; // RL21
		end
	end
	// Both paths run on clk alone, so no crossing is needed. // RL22
endmodule

/* File: mpfc_map.svh */
// Register word indices, field positions, masks and timing constants.
// Assumes word addressing: byte address is four times the word index.
`ifndef MPFC_MAP_SVH
`define MPFC_MAP_SVH
`define MPFC_W_RXCTL 6'd0
`define MPFC_W_RXEN 6'd1
`define MPFC_W_TXEN 6'd2
`define MPFC_W_UC_LO 6'd3
`define MPFC_W_UC_HI 6'd4
`define MPFC_W_MC_LO 6'd5
`define MPFC_W_MC_HI 6'd6
`define MPFC_W_SA_LO 6'd7
`define MPFC_W_SA_HI 6'd8
`define MPFC_W_RXET_C 6'd9
`define MPFC_W_RXET_P 6'd10
`define MPFC_W_OPC_G 6'd11
`define MPFC_W_OPC_P 6'd12
`define MPFC_W_OPC_X 6'd13
`define MPFC_W_TG_DA_LO 6'd14
`define MPFC_W_TG_DA_HI 6'd15
`define MPFC_W_TG_SA_LO 6'd16
`define MPFC_W_TG_SA_HI 6'd17
`define MPFC_W_TP_DA_LO 6'd18
`define MPFC_W_TP_DA_HI 6'd19
`define MPFC_W_TP_SA_LO 6'd20
`define MPFC_W_TP_SA_HI 6'd21
`define MPFC_W_TX_ET 6'd22
`define MPFC_W_TX_OP 6'd23
`define MPFC_W_TIMES 6'd24
`define MPFC_W_STATUS 6'd33
`define MPFC_NUM_CFG 33
`define MPFC_CLS_STRIDE 8
`define MPFC_CHK_W 6
`define MPFC_CHK_EN 0
`define MPFC_CHK_MC 1
`define MPFC_CHK_UC 2
`define MPFC_CHK_SA 3
`define MPFC_CHK_ET 4
`define MPFC_CHK_OP 5
`define MPFC_RXCTL_ACK 30
`define MPFC_RXCTL_FWD 31
`define MPFC_MASK_RXCTL 32'hff3f3f3f
`define MPFC_MASK_NINE 32'h000001ff
`define MPFC_MASK_HI 32'h0000ffff
`define MPFC_RST_VAL 32'h00000000
`define MPFC_QUANTUM_BITS 512
`define MPFC_CLK_PERIOD_PS 10000
`define MPFC_LINE_MBPS 25000
`endif

/* File: mpfc_pkg.sv */
// Types shared by the pause flow-control block.
// Assumes nothing beyond a SystemVerilog compiler.
package mpfc_pkg;
	typedef logic [47:0] mpfc_mac_t;
	typedef logic [15:0] mpfc_word_t;
	typedef mpfc_word_t [8:0] mpfc_q9_t;
	typedef mpfc_word_t [7:0] mpfc_q8_t;
	typedef enum logic [1:0] {CLS_GCP, CLS_PCP, CLS_GPP, CLS_PPP} mpfc_cls_t;
	typedef enum logic [1:0] {TX_IDLE, TX_OFFER, TX_FLIGHT} mpfc_txst_t;
endpackage

/* File: mpfc_core_if.sv */
// Carrier between the pause core, its header matcher and its refresh timers.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface mpfc_core_if;
	import mpfc_pkg::*;
	mpfc_mac_t da, sa, ucast, mcast, saCfg;
	mpfc_word_t etype, opcode;
	logic [31:0] ctrl;
	mpfc_word_t [3:0] etCfg, opMin, opMax;
	logic [3:0] match;
	logic tick, resend;
	logic [8:0] req, en, launch, pending;
	mpfc_q9_t refresh;
	modport matcher (input da, sa, ucast, mcast, saCfg, etype, opcode, ctrl,
		etCfg, opMin, opMax, output match);
	modport timer (input tick, resend, req, en, launch, refresh, output pending);
endinterface

/* File: mpfc_rx_match.sv */
// Classifies a received header into the four control and pause classes.
// Assumes header fields are stable while the core samples the result.
`timescale 1ns/1ps
`include "mpfc_map.svh"
module mpfc_rx_match (
	mpfc_core_if.matcher bus
);
	import mpfc_pkg::*;

	// One class: each disabled check passes
	function automatic logic classOk(input logic [5:0] c, input mpfc_word_t et,
		input mpfc_word_t lo, input mpfc_word_t hi);
		logic daOk;
		logic saOk;
		logic etOk;
		logic opOk;
		daOk = !(c[`MPFC_CHK_MC] | c[`MPFC_CHK_UC])
			| (c[`MPFC_CHK_MC] & (bus.da == bus.mcast))
			| (c[`MPFC_CHK_UC] & (bus.da == bus.ucast)); // RL3 RL4 RL5 RL6
		saOk = !c[`MPFC_CHK_SA] | (bus.sa == bus.saCfg); // RL3 RL4 RL5 RL6
		etOk = !c[`MPFC_CHK_ET] | (bus.etype == et); // RL3 RL4 RL5 RL6
		// Range check; pause classes pass lo equal to hi
		opOk = !c[`MPFC_CHK_OP] | ((bus.opcode >= lo) && (bus.opcode <= hi)); // RL3 RL4
		return c[`MPFC_CHK_EN] & daOk & saOk & etOk & opOk;
	endfunction

	// All four classes evaluated side by side
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			bus.match[k] = classOk(bus.ctrl[k * `MPFC_CLS_STRIDE +: `MPFC_CHK_W],
				bus.etCfg[k], bus.opMin[k], bus.opMax[k]);
		end
	end
endmodule

/* File: mpfc_tx_timer.sv */
// Per-class refresh timers and pending flags for transmitted pause frames.
// Assumes tick pulses once per pause quantum and launch is a one-cycle pulse.
`timescale 1ns/1ps
`include "mpfc_map.svh"
module mpfc_tx_timer (
	input wire logic clk,
	input wire logic rst_n,
	mpfc_core_if.timer bus
);
	import mpfc_pkg::*;

	logic [8:0] armed;
	logic [8:0] due;
	logic [8:0] armedPrev;
	mpfc_q9_t cnt;

	// Refresh expiry in whole quanta; zero refresh disables repeats
	always_comb begin
		for (int k = 0; k < 9; k++) begin
			armed[k] = bus.en[k] & bus.req[k]; // RL2
			due[k] = armed[k] & bus.tick & (bus.refresh[k] != 16'h0000)
				& ((cnt[k] + 16'h0001) >= bus.refresh[k]); // RL14 RL23
		end
	end

	// Counters restart on resend, on expiry and while idle
	always_ff @(posedge clk) begin
		for (int k = 0; k < 9; k++) begin
			if (!rst_n)
				cnt[k] <= 16'h0000;
			else if (bus.resend | !armed[k] | due[k])
				cnt[k] <= 16'h0000; // RL17
			else if (bus.tick)
				cnt[k] <= cnt[k] + 16'h0001; // RL14
		end
	end

	// Pending: a new set wins over the launch that clears it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus.pending <= 9'h000;
			armedPrev <= 9'h000;
		end else begin
			bus.pending <= (armed & (~armedPrev | due | {9{bus.resend}}))
				| (bus.pending & ~bus.launch & bus.en); // RL12 RL17
			armedPrev <= armed;
		end
	end
endmodule

/* File: mpfc_top_chk.sv */
// Port-level assertions for the pause flow-control block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module mpfc_top_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxHdrValid,
	input wire logic rxHdrFcsGood,
	input wire logic [8:0] rxPauseValid,
	input wire logic [8:0] rxPauseReq,
	input wire logic [8:0] rxPaused,
	input wire logic rxCtrlForward,
	input wire logic rxCtrlDrop,
	input wire logic rxStatPause,
	input wire logic rxStatUserPause,
	input wire logic txFrmValid,
	input wire logic txFrmReady,
	input wire mpfc_pkg::mpfc_word_t txFrmParam,
	input wire logic txFrmDone,
	input wire logic txFrmDoneGood,
	input wire logic [8:0] txPauseValid,
	input wire logic txStatPause,
	input wire logic txStatUserPause
);
	import mpfc_pkg::*;
	// ----------
	// Properties
	// ----------
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single access cycle");
	AST_RX_VALID_CAUSE: assert property (rxPauseValid != 9'h0 |-> $past(rxHdrValid && rxHdrFcsGood))
		else $error("pause valid without a good header");
	AST_REQ_WITH_VALID: assert property ((rxPauseValid & ~rxPauseReq) == 9'h0)
		else $error("pause valid without request");
	AST_PAUSED_LATENCY: assert property ($rose(rxPaused[8]) |-> $past(rxHdrValid, 2))
		else $error("pause timer started without header");
	AST_RX_STAT: assert property (rxStatPause |-> $past(rxHdrValid && rxHdrFcsGood))
		else $error("rx pause statistic without good frame");
	AST_RX_USTAT: assert property (rxStatUserPause |-> $past(rxHdrValid && rxHdrFcsGood))
		else $error("rx priority statistic without good frame");
	AST_CTRL_ONE: assert property (rxCtrlForward || rxCtrlDrop |-> $past(rxHdrValid) && !(rxCtrlForward && rxCtrlDrop))
		else $error("forward and drop wrong");
	AST_TX_HOLD: assert property (txFrmValid && !txFrmReady |=> txFrmValid && $stable(txFrmParam))
		else $error("offered frame changed before ready");
	AST_TX_VALID_DONE: assert property (txPauseValid != 9'h0 |-> $past(txFrmDone))
		else $error("tx pause valid without finished frame");
	AST_TX_STAT: assert property (txStatPause || txStatUserPause |-> $past(txFrmDone && txFrmDoneGood))
		else $error("tx statistic without good frame");
	// Main scenarios reached
	cover property (rxPauseValid[8]);
	cover property (txStatUserPause);
	cover property (pready && pslverr);
endmodule

/* File: mpfc_frame_sink.sv */
// Model of the MAC transmitter that takes generated pause frames.
// Assumes valid holds until ready; answers after a programmable stall.
`timescale 1ns/1ps
module mpfc_frame_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic txFrmValid,
	input wire logic [3:0] sinkStall,
	output logic txFrmReady,
	output logic txFrmDone,
	output logic txFrmDoneGood
);
	logic [3:0] cnt;
	logic busy;
	// Accept after the stall, finish seven cycles later; status toggles when unqualified
	always_ff @(posedge clk) begin
		txFrmReady <= 1'b0;
		txFrmDone <= 1'b0;
		txFrmDoneGood <= ~txFrmDoneGood;
		if (!rst_n) begin
			cnt <= 4'h0;
			busy <= 1'b0;
			txFrmDoneGood <= 1'b0;
		end else if (txFrmValid && !txFrmReady && !busy) begin
			cnt <= (cnt == sinkStall) ? 4'h0 : cnt + 4'h1;
			txFrmReady <= (cnt == sinkStall);
			busy <= (cnt == sinkStall);
		end else if (busy) begin
			cnt <= (cnt == 4'h6) ? 4'h0 : cnt + 4'h1;
			if (cnt == 4'h6) begin
				txFrmDone <= 1'b1;
				txFrmDoneGood <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule

/* File: test_mpfc_top.sv */
// Self-checking bench for the pause flow-control block.
// Assumes the block, its checker and the frame sink compile first.
`timescale 1ns/1ps
module test_mpfc_top;
	import mpfc_pkg::*;
	typedef struct {logic [15:0] opc; logic [15:0] prm; logic fcs; logic [8:0] vld;
		logic [2:0] flg;} mpfc_row_t;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic rxHdrValid = 1'h0, rxHdrFcsGood = 1'h0, txResendPause = 1'h0;
	mpfc_mac_t rxHdrDa = 48'h0, rxHdrSa = 48'h0, txFrmDa, txFrmSa;
	mpfc_word_t rxHdrEtype = 16'h8808, rxHdrOpcode = 16'h0, rxHdrParam = 16'h0;
	mpfc_word_t txFrmEtype, txFrmOpcode, txFrmParam;
	mpfc_q8_t rxHdrTimes = {8{16'h0010}}, txFrmTimes;
	mpfc_q9_t rxPauseQuanta;
	logic [8:0] rxPauseAck = 9'h0, txPauseReq = 9'h0, rxPauseReq, rxPauseValid, rxPaused;
	logic [8:0] txPauseValid;
	logic rxCtrlForward, rxCtrlDrop, rxStatPause, rxStatUserPause, txStatPause;
	logic txStatUserPause, txFrmValid, txFrmReady, txFrmDone, txFrmDoneGood;
	logic [3:0] sinkStall = 4'h3;
	int num_errors = 0, n_compared = 0, cyc = 0, k;
	// Ordinary headers: opcode, param, fcs, expected valid, {forward, stat, user stat}
	mpfc_row_t rows [5] = '{'{16'h0001, 16'h0040, 1'h1, 9'h100, 3'h6},
		'{16'h0001, 16'h0040, 1'h0, 9'h000, 3'h4}, '{16'h0101, 16'h0005, 1'h1, 9'h005, 3'h5},
		'{16'h0002, 16'h0005, 1'h1, 9'h000, 3'h0}, '{16'h0101, 16'h0080, 1'h1, 9'h080, 3'h5}};
	mpfc_top i_mpfc_top (.*);
	mpfc_frame_sink i_mpfc_frame_sink (.*);
	// Clock and a hang guard well above the expected run
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask
	// Full APB transfer; waits on pready, never on a fixed count
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// One parsed header strobe; returns just after the answering edge
	task automatic hdr(input logic [15:0] o, input logic [15:0] p, input logic f);
		@(posedge clk);
		rxHdrValid <= 1'h1;
		rxHdrOpcode <= o;
		rxHdrParam <= p;
		rxHdrFcsGood <= f;
		@(posedge clk);
		rxHdrValid <= 1'h0;
		#1;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// -------------
	// Main sequence
	// -------------
	initial begin
		repeat (4) @(posedge clk);
		chk("reset outputs", 32'h0, {4'h0, rxPauseReq, rxPauseValid, txPauseValid, txFrmValid});
		rst_n <= 1'h1;
		apb(1'h0, 8'h00, 32'h0);
		chk("control reset", 32'h0, rd);
		apb(1'h0, 8'h88, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		// Both pause classes with opcode checks, forwarding and waiting for ack
		apb(1'h1, 8'h00, 32'he121_0000);
		apb(1'h1, 8'h04, 32'h0000_01ff);
		apb(1'h1, 8'h34, 32'h0101_0001);
		apb(1'h0, 8'h00, 32'h0);
		chk("control", 32'he121_0000, rd);
		foreach (rows[i]) begin
			hdr(rows[i].opc, rows[i].prm, rows[i].fcs);
			chk("rx valid", {23'h0, rows[i].vld}, {23'h0, rxPauseValid});
			chk("rx flags", {29'h0, rows[i].flg}, {29'h0, rxCtrlForward, rxStatPause, rxStatUserPause});
		end
		chk("global quanta", 32'h0040, {16'h0, rxPauseQuanta[8]});
		chk("priority quanta", 32'h0010, {16'h0, rxPauseQuanta[2]});
		chk("held requests", 32'h185, {23'h0, rxPauseReq});
		@(posedge clk);
		rxPauseAck <= 9'h100;
		@(posedge clk);
		rxPauseAck <= 9'h0;
		#1;
		chk("request after ack", 32'h085, {23'h0, rxPauseReq});
		// Global timer from the first row runs out, so the masked frame must restart it
		for (k = 0; k < 300 && rxPaused[8] === 1'h1; k++) @(posedge clk);
		chk("timer expired", 32'h0, {31'h0, rxPaused[8]});
		// Global class masked on the user side, control frames dropped
		apb(1'h1, 8'h04, 32'h0000_00ff);
		apb(1'h1, 8'h00, 32'h6121_0000);
		hdr(16'h0001, 16'h0040, 1'h1);
		chk("masked valid", 32'h0, {23'h0, rxPauseValid});
		chk("drop", 32'h2, {30'h0, rxCtrlDrop, rxCtrlForward});
		@(posedge clk);
		#1;
		chk("timer runs", 32'h1, {31'h0, rxPaused[8]});
		// Transmit: priority 3 enabled, global not
		apb(1'h1, 8'h08, 32'h0000_0008);
		apb(1'h1, 8'h6c, 32'h0000_0123);
		apb(1'h1, 8'h58, 32'h1234_5678);
		apb(1'h1, 8'h5c, 32'h0101_0001);
		apb(1'h1, 8'h4c, 32'h0000_abcd);
		apb(1'h1, 8'h50, 32'h0000_9876);
		apb(1'h1, 8'h80, 32'h0000_0077);
		txPauseReq <= 9'h100;
		repeat (10) @(posedge clk);
		chk("global refused", 32'h0, {31'h0, txFrmValid});
		txPauseReq <= 9'h108;
		for (k = 0; k < 50 && txFrmValid !== 1'h1; k++) @(posedge clk);
		chk("tx header", 32'h1234_0101, {txFrmEtype, txFrmOpcode});
		chk("tx quanta", 32'h0123_0008, {txFrmTimes[3], txFrmParam});
		chk("tx addresses", 32'habcd_9876, {txFrmDa[47:32], txFrmSa[15:0]});
		for (k = 0; k < 50 && txPauseValid === 9'h0; k++) @(posedge clk);
		chk("tx sent", 32'h1008, {19'h0, txStatUserPause, 3'h0, txPauseValid});
		txResendPause <= 1'h1;
		@(posedge clk);
		txResendPause <= 1'h0;
		for (k = 0; k < 50 && txFrmValid !== 1'h1; k++) @(posedge clk);
		chk("resend", 32'h1, {31'h0, txFrmValid});
		for (k = 0; k < 50 && txPauseValid === 9'h0; k++) @(posedge clk);
		// Global enabled late: its held request now counts as a new one
		apb(1'h1, 8'h08, 32'h0000_0108);
		for (k = 0; k < 50 && txFrmValid !== 1'h1; k++) @(posedge clk);
		chk("global header", 32'h5678_0001, {txFrmEtype, txFrmOpcode});
		chk("global param", 32'h0077, {16'h0, txFrmParam});
		for (k = 0; k < 50 && txPauseValid === 9'h0; k++) @(posedge clk);
		chk("global sent", 32'h1100, {19'h0, txStatPause, 3'h0, txPauseValid});
		results();
	end
endmodule
bind mpfc_top mpfc_top_chk i_mpfc_top_chk (.*);
